// ### rtl/fpc_pkg.sv
package fpc_pkg;

  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  localparam int NUM_COUNTERS  = 6;
  localparam int NUM_MAIN      = 3;
  localparam int NUM_PINS      = 12;
  localparam int PINS_PER_MAIN = 4;
  localparam int SUB_PIN_OFS   = 2;   // Sub counter uses the top two pins of its main group
  localparam int OUT_W         = 16;
  localparam int WORD_W        = 16;
  localparam int LONG_W        = 32;
  localparam int SEL_W         = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 50000000;
  localparam int MAX_PULSE_HZ  = 100000;
  // Least clocks between two input pulses at the top rate
  localparam int PULSE_CYCLES  = CLK_HZ / MAX_PULSE_HZ;

  // ----------------------------------------------------------------
  // Limits, codes and reset values
  // ----------------------------------------------------------------
  localparam logic [WORD_W-1:0] MODE_MAX     = 16'h0009;
  localparam logic [WORD_W-1:0] MODE_LOW_MIN = 16'h0002;
  localparam logic [WORD_W-1:0] ROUTINE_MIN  = 16'h0003;
  localparam logic [WORD_W-1:0] ROUTINE_MAX  = 16'h00ff;

  localparam logic [WORD_W-1:0] ERR_NONE      = 16'h0000;
  localparam logic [WORD_W-1:0] ERR_ROUTINE   = 16'h0001;
  localparam logic [WORD_W-1:0] ERR_MODE      = 16'h0002;
  localparam logic [WORD_W-1:0] ERR_HIGH      = 16'h0003;
  localparam logic [WORD_W-1:0] ERR_OVERFLOW  = 16'h0004;
  localparam logic [WORD_W-1:0] ERR_UNDERFLOW = 16'h0005;

  localparam logic signed [LONG_W-1:0] LONG_ZERO = 32'sh0000_0000;
  localparam logic signed [LONG_W-1:0] LONG_STEP = 32'sh0000_0001;
  localparam logic signed [LONG_W-1:0] HIP_RST   = 32'sh0000_0000;
  localparam logic signed [LONG_W-1:0] LOP_RST   = 32'sh0000_0000;
  localparam logic signed [LONG_W-1:0] OVF_RST   = 32'sh7fff_ffff;
  localparam logic signed [LONG_W-1:0] UNF_RST   = 32'sh8000_0001;
  localparam logic [WORD_W-1:0]        WORD_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Sub-element select codes
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    EL_ROUTINE_NUMBER, EL_ERROR_CODE, EL_EXECUTING, EL_ROUTINE_ENABLE,
    EL_LOST, EL_PENDING, EL_FUNCTION_ACTIVE, EL_START_ON_RUN, EL_FAULT,
    EL_COUNT_ENABLE, EL_PARAM_LOAD, EL_LOWER_MASK, EL_UPPER_MASK,
    EL_UNDER_MASK, EL_OVER_MASK, EL_LOWER_IRQ, EL_UPPER_IRQ, EL_UNDER_IRQ,
    EL_OVER_IRQ, EL_LOWER_HIT, EL_UPPER_HIT, EL_DIRECTION, EL_UNDERFLOW,
    EL_OVERFLOW, EL_MODE_DONE, EL_COUNTING_DOWN, EL_COUNTING_UP, EL_MODE,
    EL_ACCUMULATED, EL_UPPER_PRESET, EL_LOWER_PRESET, EL_OVER_SETPOINT,
    EL_UNDER_SETPOINT, EL_OUTPUT_MASK, EL_UPPER_PATTERN, EL_LOWER_PATTERN
  } fpc_elem_e;

  // Configuration stored with the user program, loaded on a parameter load
  typedef struct packed {
    logic [WORD_W-1:0] routine_number;
    logic [WORD_W-1:0] mode;
    logic [OUT_W-1:0]  output_mask;
    logic              start_on_run;
  } fpc_cfg_s;

  // Control program access to one sub-element
  typedef struct packed {
    logic [SEL_W-1:0]  sel;
    fpc_elem_e         elem;
    logic              wr;
    logic              rd;
    logic [LONG_W-1:0] wdata;
  } fpc_req_s;

endpackage

// ### rtl/fpc_counter_set.sv
`timescale 1ns/1ps
// Behaviour
// - Six independent pulse counters, each counting pulses up to 100 kHz.
// - Counters 0 to 2 are main counters, 3 to 5 reduced sub counters.
// - Main counters use four dedicated inputs, sub counters exactly two.
// - Main counters use inputs 0-3, 4-7 and 8-11 respectively.
// - Sub counters use inputs 2-3, 6-7, 10-11, shared with their main counter.
// - Sub counter goes inactive when its main counter's mode needs the shared inputs.
// - Counting runs in dedicated logic, independent of program execution.
// - Main counters offer ten modes, sub counters five.
// - Count and setpoints are 32-bit signed integers.
// - Count is compared with high preset, low preset, overflow and underflow.
// - Preset and setpoint events raise interrupt requests without the processor.
// - Preset events drive outputs from 16-bit patterns filtered by the output mask.
// - Each counter exposes 36 bit, word and long-word sub-elements.
// - Low preset and underflow features act only in modes 2 to 9.
// - Count, presets, setpoints and output patterns are writable while running.
// - Routine number, error code, mode, auto start and output mask are read only.
// - Lost, preset and overflow/underflow irq flags and event flags are writable.
// - Executing, pending, fault, direction, up, down and hit flags are read only.
// - Status reads show live values that change while counting.
// - Clearing counting enable freezes the count; setting it resumes; default clear.
// - Rising parameter load checks and loads configuration without losing counts.
// - Error codes: 1 routine, 2 mode, 3 high preset, 4 overflow, 5 underflow.
// - Fault flag follows whether a configuration error is present.
module fpc_counter_set
  import fpc_pkg::*;
#(
  parameter int OUT_BITS = fpc_pkg::OUT_W
) (
  input  wire logic                                     clk_i,
  input  wire logic                                     reset_n_i,
  input  wire logic                                     run_mode_i,
  input  wire logic [fpc_pkg::NUM_PINS-1:0]             pins_i,
  input  wire fpc_pkg::fpc_cfg_s [fpc_pkg::NUM_COUNTERS-1:0] cfg_i,
  input  wire fpc_pkg::fpc_req_s                        req_i,
  output logic      [fpc_pkg::LONG_W-1:0]               rdata_o,
  output logic                                          rvalid_o,
  output logic      [fpc_pkg::NUM_COUNTERS-1:0]         routine_request_o,
  input  wire logic [fpc_pkg::NUM_COUNTERS-1:0]         routine_start_i,
  input  wire logic [fpc_pkg::NUM_COUNTERS-1:0]         routine_done_i,
  output logic      [OUT_BITS-1:0]                      outputs_o
);
  import fpc_pkg::*;

  if (OUT_BITS < 1 || OUT_BITS > OUT_W) begin : g_bad_width
    $error("OUT_BITS must lie between 1 and the pattern width");
  end

  // ----------------------------------------------------------------
  // Input pins
  // ----------------------------------------------------------------
  logic [NUM_PINS-1:0] pin_meta_q;
  logic [NUM_PINS-1:0] pin_sync_q;
  logic [NUM_PINS-1:0] pin_old_q;

  // Two-stage synchroniser, then one stage for edge detection
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      pin_old_q  <= '0;
    end else begin
      pin_meta_q <= pins_i;
      pin_sync_q <= pin_meta_q;
      pin_old_q  <= pin_sync_q;
    end
  end

  // Run mode edge for auto start
  logic run_old_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_old_q <= 1'b0;
    end else begin
      run_old_q <= run_mode_i;
    end
  end
  logic run_rise;
  assign run_rise = run_mode_i & ~run_old_q;

  // Configuration check, in order of error code
  function automatic logic [WORD_W-1:0] cfg_error(
    input fpc_cfg_s                  c,
    input logic                      is_main,
    input logic signed [LONG_W-1:0]  upper_preset_value,
    input logic signed [LONG_W-1:0]  lower_preset_value,
    input logic signed [LONG_W-1:0]  ovf,
    input logic signed [LONG_W-1:0]  unf
  );
    logic low;
    low = c.mode >= MODE_LOW_MIN;
    if (c.routine_number < ROUTINE_MIN || c.routine_number > ROUTINE_MAX)
      return ERR_ROUTINE;
    if (c.mode > MODE_MAX || (!is_main && c.mode[0]))
      return ERR_MODE;
    if ((!low && upper_preset_value <= LONG_ZERO) || (low && upper_preset_value <= lower_preset_value))
      return ERR_HIGH;
    if (upper_preset_value > ovf)
      return ERR_OVERFLOW;
    if (low && lower_preset_value < unf)
      return ERR_UNDERFLOW;
    return ERR_NONE;
  endfunction

  logic [LONG_W-1:0] rd_word [NUM_COUNTERS];
  logic [OUT_W-1:0]  drive_w [NUM_COUNTERS];
  logic [WORD_W-1:0] mode_w  [NUM_COUNTERS];

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_cnt
    localparam bit IS_MAIN = (i < NUM_MAIN);
    localparam int PA = IS_MAIN ? i * PINS_PER_MAIN
                                : (i - NUM_MAIN) * PINS_PER_MAIN + SUB_PIN_OFS;

    logic a_now, a_old, b_now, b_old, c_rise, hold, forced_off;
    assign a_now = pin_sync_q[PA];
    assign a_old = pin_old_q[PA];
    assign b_now = pin_sync_q[PA+1];
    assign b_old = pin_old_q[PA+1];
    if (IS_MAIN) begin : g_main
      assign c_rise     = pin_sync_q[PA+2] & ~pin_old_q[PA+2];
      assign hold       = pin_sync_q[PA+3];
      assign forced_off = 1'b0;
    end else begin : g_sub
      assign c_rise     = 1'b0;
      assign hold       = 1'b0;
      assign forced_off = mode_w[i-NUM_MAIN][0];
    end

    logic [WORD_W-1:0]        mode_q, routine_q, err_q;
    logic [OUT_W-1:0]         mask_q, out_q, hpo_q, lpo_q;
    logic                     start_q;
    logic signed [LONG_W-1:0] acc_q, hip_q, lop_q, ovf_q, unf_q;
    logic fa_q, ce_q, pl_q, pl_old_q, ren_q, pend_q, exec_q, lost_q;
    logic lpm_q, hpm_q, ufm_q, ofm_q, lpi_q, hpi_q, ufi_q, ofi_q;
    logic of_q, uf_q, md_q, dir_q, hp_old_q, lp_old_q;
    assign mode_w[i] = mode_q;

    // Program write strobes
    logic wr;
    assign wr = req_i.wr && (req_i.sel == SEL_W'(i));
    function automatic logic we(input fpc_elem_e e);
      return wr && req_i.elem == e;
    endfunction

    logic fault, low_ok, with_reset, run_ok, pl_rise;
    assign fault      = err_q != ERR_NONE;
    assign low_ok     = mode_q >= MODE_LOW_MIN;
    assign with_reset = IS_MAIN && mode_q[0];
    assign run_ok     = fa_q & ce_q & ~fault & ~forced_off & ~(with_reset & hold);
    assign pl_rise    = pl_q & ~pl_old_q;

    // Per-mode edge qualification
    logic a_rise, a_chg, b_rise, b_chg, up_raw, dn_raw;
    assign a_rise = a_now & ~a_old;
    assign a_chg  = a_now ^ a_old;
    assign b_rise = b_now & ~b_old;
    assign b_chg  = b_now ^ b_old;
    always_comb begin
      up_raw = 1'b0;
      dn_raw = 1'b0;
      unique case (mode_q[3:1])
        3'h0: up_raw = a_rise;
        3'h1: begin
          up_raw = a_rise & ~b_now;
          dn_raw = a_rise & b_now;
        end
        3'h2: begin
          up_raw = a_rise & ~b_rise;
          dn_raw = b_rise & ~a_rise;
        end
        3'h3: begin
          up_raw = a_rise & ~b_now;
          dn_raw = a_rise & b_now;
        end
        3'h4: begin
          up_raw = (a_chg & ~b_chg & (a_now != b_now)) | (b_chg & ~a_chg & (a_now == b_now));
          dn_raw = (a_chg & ~b_chg & (a_now == b_now)) | (b_chg & ~a_chg & (a_now != b_now));
        end
        default: begin
          up_raw = 1'b0;
          dn_raw = 1'b0;
        end
      endcase
    end

    logic step_up, step_dn, of_evt, uf_evt, md_evt, hp_hit, lp_hit, hp_evt, lp_evt, any_evt;
    logic signed [LONG_W-1:0] acc_inc;
    assign step_up = run_ok & up_raw;
    assign step_dn = run_ok & dn_raw & low_ok;
    assign acc_inc = acc_q + LONG_STEP;
    assign of_evt  = step_up & (acc_q == ovf_q);
    assign uf_evt  = step_dn & (acc_q == unf_q);
    assign md_evt  = step_up & ~low_ok & ~of_evt & (acc_inc >= hip_q);
    assign hp_hit  = low_ok & (acc_q >= hip_q);
    assign lp_hit  = low_ok & (acc_q <= lop_q);
    assign hp_evt  = low_ok ? (hp_hit & ~hp_old_q & fa_q) : md_evt;
    assign lp_evt  = lp_hit & ~lp_old_q & fa_q;
    assign any_evt = (hp_evt & hpm_q) | (lp_evt & lpm_q) | (of_evt & ofm_q) | (uf_evt & ufm_q);

    // Working configuration, checked and loaded on a parameter load edge
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        mode_q    <= WORD_ZERO;
        routine_q <= ROUTINE_MIN;
        mask_q    <= WORD_ZERO;
        start_q   <= 1'b0;
        err_q     <= ERR_NONE;
        pl_old_q  <= 1'b0;
      end else begin
        pl_old_q <= pl_q;
        if (pl_rise) begin
          mode_q    <= cfg_i[i].mode;
          routine_q <= cfg_i[i].routine_number;
          mask_q    <= cfg_i[i].output_mask;
          start_q   <= cfg_i[i].start_on_run;
          err_q     <= cfg_error(cfg_i[i], IS_MAIN, hip_q, lop_q, ovf_q, unf_q);
        end
      end
    end

    // Accumulator and direction
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        acc_q <= LONG_ZERO;
        dir_q <= 1'b0;
      end else begin
        if (we(EL_ACCUMULATED)) begin
          acc_q <= signed'(req_i.wdata);
        end else if (with_reset & c_rise & ~fault) begin
          acc_q <= LONG_ZERO;
        end else if (step_up) begin
          if (of_evt)
            acc_q <= low_ok ? unf_q : LONG_ZERO;
          else if (md_evt)
            acc_q <= LONG_ZERO;
          else
            acc_q <= acc_inc;
        end else if (step_dn) begin
          acc_q <= uf_evt ? ovf_q : acc_q - LONG_STEP;
        end
        if (step_up)
          dir_q <= 1'b0;
        else if (step_dn)
          dir_q <= 1'b1;
      end
    end

    // Presets, setpoints and patterns, editable while running
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        hip_q <= HIP_RST;
        lop_q <= LOP_RST;
        ovf_q <= OVF_RST;
        unf_q <= UNF_RST;
        hpo_q <= WORD_ZERO;
        lpo_q <= WORD_ZERO;
      end else begin
        if (we(EL_UPPER_PRESET))   hip_q <= signed'(req_i.wdata);
        if (we(EL_LOWER_PRESET))   lop_q <= signed'(req_i.wdata);
        if (we(EL_OVER_SETPOINT))  ovf_q <= signed'(req_i.wdata);
        if (we(EL_UNDER_SETPOINT)) unf_q <= signed'(req_i.wdata);
        if (we(EL_UPPER_PATTERN))  hpo_q <= req_i.wdata[OUT_W-1:0];
        if (we(EL_LOWER_PATTERN))  lpo_q <= req_i.wdata[OUT_W-1:0];
      end
    end

    // Control bits written by the program; auto start sets function active
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        fa_q <= 1'b0;
        ce_q <= 1'b0;
        pl_q <= 1'b0;
        ren_q <= 1'b0;
        lpm_q <= 1'b0;
        hpm_q <= 1'b0;
        ufm_q <= 1'b0;
        ofm_q <= 1'b0;
      end else begin
        fa_q <= (run_rise & start_q) | (we(EL_FUNCTION_ACTIVE) ? req_i.wdata[0] : fa_q);
        if (we(EL_COUNT_ENABLE))   ce_q  <= req_i.wdata[0];
        if (we(EL_PARAM_LOAD))     pl_q  <= req_i.wdata[0];
        if (we(EL_ROUTINE_ENABLE)) ren_q <= req_i.wdata[0];
        if (we(EL_LOWER_MASK))     lpm_q <= req_i.wdata[0];
        if (we(EL_UPPER_MASK))     hpm_q <= req_i.wdata[0];
        if (we(EL_UNDER_MASK))     ufm_q <= req_i.wdata[0];
        if (we(EL_OVER_MASK))      ofm_q <= req_i.wdata[0];
      end
    end

    // Event flags: hardware set wins over a program clear
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        lpi_q <= 1'b0;
        hpi_q <= 1'b0;
        ufi_q <= 1'b0;
        ofi_q <= 1'b0;
        of_q  <= 1'b0;
        uf_q  <= 1'b0;
        md_q  <= 1'b0;
        hp_old_q <= 1'b0;
        lp_old_q <= 1'b0;
      end else begin
        hp_old_q <= hp_hit;
        lp_old_q <= lp_hit;
        hpi_q <= (hp_evt & hpm_q) | (we(EL_UPPER_IRQ) ? req_i.wdata[0] : hpi_q);
        lpi_q <= (lp_evt & lpm_q) | (we(EL_LOWER_IRQ) ? req_i.wdata[0] : lpi_q);
        ofi_q <= (of_evt & ofm_q) | (we(EL_OVER_IRQ) ? req_i.wdata[0] : ofi_q);
        ufi_q <= (uf_evt & ufm_q) | (we(EL_UNDER_IRQ) ? req_i.wdata[0] : ufi_q);
        of_q  <= of_evt | (we(EL_OVERFLOW) ? req_i.wdata[0] : of_q);
        uf_q  <= uf_evt | (we(EL_UNDERFLOW) ? req_i.wdata[0] : uf_q);
        md_q  <= md_evt | (we(EL_MODE_DONE) ? req_i.wdata[0] : md_q);
      end
    end

    // Interrupt routine request: pending, executing and lost
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        pend_q <= 1'b0;
        exec_q <= 1'b0;
        lost_q <= 1'b0;
      end else begin
        if (any_evt & ren_q)
          pend_q <= 1'b1;
        else if (routine_start_i[i] & pend_q)
          pend_q <= 1'b0;
        if (routine_start_i[i] & pend_q)
          exec_q <= 1'b1;
        else if (routine_done_i[i])
          exec_q <= 1'b0;
        lost_q <= (any_evt & ren_q & pend_q) | (we(EL_LOST) ? req_i.wdata[0] : lost_q);
      end
    end
    assign routine_request_o[i] = pend_q & fa_q & ~exec_q;

    // Direct output control on preset events
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        out_q <= WORD_ZERO;
      end else if (hp_evt) begin
        out_q <= (out_q & ~mask_q) | (hpo_q & mask_q);
      end else if (lp_evt) begin
        out_q <= (out_q & ~mask_q) | (lpo_q & mask_q);
      end
    end
    assign drive_w[i] = out_q;

    // Live read of every sub-element
    logic active;
    assign active = run_ok;
    always_comb begin
      rd_word[i] = '0;
      unique case (req_i.elem)
        EL_ROUTINE_NUMBER:  rd_word[i] = {16'h0000, routine_q};
        EL_ERROR_CODE:      rd_word[i] = {16'h0000, err_q};
        EL_EXECUTING:       rd_word[i][0] = exec_q;
        EL_ROUTINE_ENABLE:  rd_word[i][0] = ren_q;
        EL_LOST:            rd_word[i][0] = lost_q;
        EL_PENDING:         rd_word[i][0] = pend_q;
        EL_FUNCTION_ACTIVE: rd_word[i][0] = fa_q;
        EL_START_ON_RUN:    rd_word[i][0] = start_q;
        EL_FAULT:           rd_word[i][0] = fault;
        EL_COUNT_ENABLE:    rd_word[i][0] = ce_q;
        EL_PARAM_LOAD:      rd_word[i][0] = pl_q;
        EL_LOWER_MASK:      rd_word[i][0] = lpm_q;
        EL_UPPER_MASK:      rd_word[i][0] = hpm_q;
        EL_UNDER_MASK:      rd_word[i][0] = ufm_q;
        EL_OVER_MASK:       rd_word[i][0] = ofm_q;
        EL_LOWER_IRQ:       rd_word[i][0] = lpi_q;
        EL_UPPER_IRQ:       rd_word[i][0] = hpi_q;
        EL_UNDER_IRQ:       rd_word[i][0] = ufi_q;
        EL_OVER_IRQ:        rd_word[i][0] = ofi_q;
        EL_LOWER_HIT:       rd_word[i][0] = lp_hit;
        EL_UPPER_HIT:       rd_word[i][0] = hp_hit;
        EL_DIRECTION:       rd_word[i][0] = dir_q;
        EL_UNDERFLOW:       rd_word[i][0] = uf_q;
        EL_OVERFLOW:        rd_word[i][0] = of_q;
        EL_MODE_DONE:       rd_word[i][0] = md_q;
        EL_COUNTING_DOWN:   rd_word[i][0] = active & dir_q & low_ok;
        EL_COUNTING_UP:     rd_word[i][0] = active & ~dir_q;
        EL_MODE:            rd_word[i] = {16'h0000, mode_q};
        EL_ACCUMULATED:     rd_word[i] = acc_q;
        EL_UPPER_PRESET:    rd_word[i] = hip_q;
        EL_LOWER_PRESET:    rd_word[i] = lop_q;
        EL_OVER_SETPOINT:   rd_word[i] = ovf_q;
        EL_UNDER_SETPOINT:  rd_word[i] = unf_q;
        EL_OUTPUT_MASK:     rd_word[i] = {16'h0000, mask_q};
        EL_UPPER_PATTERN:   rd_word[i] = {16'h0000, hpo_q};
        EL_LOWER_PATTERN:   rd_word[i] = {16'h0000, lpo_q};
        default:            rd_word[i] = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read port and output pins
  // ----------------------------------------------------------------
  // Read data registered one cycle after the read strobe
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o  <= '0;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      if (req_i.rd)
        rdata_o <= (req_i.sel < SEL_W'(NUM_COUNTERS)) ? rd_word[req_i.sel] : '0;
    end
  end

  // Outputs are the union of every counter's pattern word
  logic [OUT_W-1:0] drive_or;
  always_comb begin
    drive_or = '0;
    for (int k = 0; k < NUM_COUNTERS; k++) begin
      drive_or = drive_or | drive_w[k];
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      outputs_o <= '0;
    end else begin
      outputs_o <= drive_or[OUT_BITS-1:0];
    end
  end

endmodule

// ### test/fpc_pulse_src.sv
`timescale 1ns/1ps
// Field pulse source on the embedded inputs, idle low
module fpc_pulse_src (
  input  wire logic                         clk_i,
  output logic      [fpc_pkg::NUM_PINS-1:0] pins_o
);
  initial pins_o = '0;
  // Static level on one input, such as a direction pin
  task automatic level(input int pin, input logic v);
    @(negedge clk_i) pins_o[pin] = v;
  endtask
  // Pulse train, 250 clocks per half period, so 100 kHz at most
  task automatic pulse(input int pin, input int n);
    repeat (n) begin
      @(negedge clk_i) pins_o[pin] = 1'b1;
      repeat (250) @(negedge clk_i);
      pins_o[pin] = 1'b0;
      repeat (250) @(negedge clk_i);
    end
  endtask
endmodule

// ### test/fpc_counter_set_chk.sv
`timescale 1ns/1ps
// Checks on the program port and routine requests, cover only on the outputs
module fpc_counter_set_chk
  import fpc_pkg::*;
#(
  parameter int OUT_BITS = fpc_pkg::OUT_W
) (
  input wire logic                              clk_i,
  input wire logic                              reset_n_i,
  input wire fpc_pkg::fpc_req_s                 req_i,
  input wire logic [fpc_pkg::LONG_W-1:0]        rdata_o,
  input wire logic                              rvalid_o,
  input wire logic [fpc_pkg::NUM_COUNTERS-1:0]  routine_request_o,
  input wire logic [fpc_pkg::NUM_COUNTERS-1:0]  routine_start_i,
  input wire logic [fpc_pkg::NUM_COUNTERS-1:0]  routine_done_i,
  input wire logic [OUT_BITS-1:0]               outputs_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_rd_ans; req_i.rd |=> rvalid_o; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_no_rv; !req_i.rd |=> !rvalid_o; endproperty
  a_no_rv: assert property (p_no_rv) else $error("spurious rvalid");
  property p_hold; !rvalid_o |-> $stable(rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_nosel; req_i.rd && req_i.sel > 3'd5 |=> rdata_o == 32'h0; endproperty
  a_nosel: assert property (p_nosel) else $error("unused counter read");
  property p_err; req_i.rd && req_i.elem == EL_ERROR_CODE |=> rdata_o <= 32'h5; endproperty
  a_err: assert property (p_err) else $error("error code range");
  property p_bit; req_i.rd && req_i.elem == EL_FAULT |=> rdata_o[31:1] == 31'h0; endproperty
  a_bit: assert property (p_bit) else $error("bit read width");
  property p_wr_rd;
    req_i.wr && req_i.elem == EL_UPPER_PRESET ##1 !req_i.wr ##1 req_i.rd && !req_i.wr
      && req_i.elem == EL_UPPER_PRESET && req_i.sel == $past(req_i.sel, 2)
      |=> rdata_o == $past(req_i.wdata, 3);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("preset write lost");
  property p_start;
    routine_start_i[0] && routine_request_o[0] && !routine_done_i[0] |=> !routine_request_o[0];
  endproperty
  a_start: assert property (p_start) else $error("request after start");
  c_read: cover property (rvalid_o);
  c_req: cover property (routine_request_o != 6'h00);
  c_out: cover property (outputs_o != '0);
endmodule
bind fpc_counter_set fpc_counter_set_chk #(.OUT_BITS(OUT_BITS)) u_chk (
  .clk_i, .reset_n_i, .req_i, .rdata_o, .rvalid_o,
  .routine_request_o, .routine_start_i, .routine_done_i, .outputs_o
);

// ### test/tb_fpc_counter_set.sv
`timescale 1ns/1ps
module tb_fpc_counter_set;
  import fpc_pkg::*;
  logic clk_i, reset_n_i, run_mode;
  logic [NUM_PINS-1:0] pins;
  fpc_cfg_s [NUM_COUNTERS-1:0] cfg;
  fpc_req_s req;
  logic [LONG_W-1:0] rdata;
  logic rvalid;
  logic [NUM_COUNTERS-1:0] rreq, rstart, rdone;
  logic [OUT_W-1:0] outs;
  int failures, checks;
  fpc_pulse_src src (.clk_i(clk_i), .pins_o(pins));
  fpc_counter_set dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .run_mode_i(run_mode),
    .pins_i(pins), .cfg_i(cfg), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
    .routine_request_o(rreq), .routine_start_i(rstart), .routine_done_i(rdone),
    .outputs_o(outs));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input int s, input fpc_elem_e e, input logic [31:0] d);
    @(negedge clk_i) req = '{sel: 3'(s), elem: e, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk_i) req.wr = 1'b0;
  endtask
  task automatic rd(input int s, input fpc_elem_e e, input logic [31:0] x);
    @(negedge clk_i) req = '{sel: 3'(s), elem: e, wr: 1'b0, rd: 1'b1, wdata: 32'h0};
    @(negedge clk_i);
    chk("rvalid", {31'h0, rvalid}, 32'h1);
    chk(e.name(), rdata, x);
    req.rd = 1'b0;
  endtask
  task automatic load(input int s, input logic [15:0] r, input logic [15:0] m,
                      input logic [15:0] x);
    @(negedge clk_i) cfg[s].routine_number = r;
    cfg[s].mode = m;
    wr(s, EL_PARAM_LOAD, 0);
    wr(s, EL_PARAM_LOAD, 1);
    rd(s, EL_ERROR_CODE, {16'h0, x});
  endtask
  task automatic end_sim();
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    failures = 0;
    checks = 0;
    reset_n_i = 1'b0;
    req = '0;
    rstart = 6'h00;
    rdone = 6'h00;
    run_mode = 1'b0;
    for (int i = 0; i < NUM_COUNTERS; i++) cfg[i] = '{16'h3, 16'h0, 16'h00ff, 1'b0};
    repeat (12) @(negedge clk_i);
    reset_n_i = 1'b1;
    rd(0, EL_OVER_SETPOINT, 32'h7fffffff);
    rd(0, EL_UNDER_SETPOINT, 32'h80000001);
    rd(0, EL_COUNT_ENABLE, 32'h0);
    wr(0, EL_MODE, 32'h5);
    wr(0, EL_FAULT, 32'h1);
    rd(0, EL_MODE, 32'h0);
    rd(0, EL_FAULT, 32'h0);
    rd(6, EL_OVER_SETPOINT, 32'h0);
    // Configuration checks on each error code
    load(0, 16'h2, 16'h0, 16'h1);
    rd(0, EL_FAULT, 32'h1);
    load(0, 16'h3, 16'ha, 16'h2);
    load(3, 16'h3, 16'h1, 16'h2);
    load(0, 16'h3, 16'h0, 16'h3);
    wr(0, EL_OVER_SETPOINT, 32'h32);
    wr(0, EL_UPPER_PRESET, 32'h64);
    load(0, 16'h3, 16'h0, 16'h4);
    wr(0, EL_OVER_SETPOINT, 32'h7fffffff);
    wr(0, EL_UNDER_SETPOINT, -5);
    wr(0, EL_LOWER_PRESET, -10);
    load(0, 16'h3, 16'h2, 16'h5);
    load(0, 16'h3, 16'h0, 16'h0);
    wr(3, EL_UPPER_PRESET, 32'h64);
    load(3, 16'h3, 16'h0, 16'h0);
    // Counting, hold and resume, shared sub input
    wr(0, EL_FUNCTION_ACTIVE, 1);
    wr(0, EL_COUNT_ENABLE, 1);
    src.pulse(0, 5);
    rd(0, EL_ACCUMULATED, 32'h5);
    rd(0, EL_DIRECTION, 32'h0);
    wr(0, EL_COUNT_ENABLE, 0);
    src.pulse(0, 2);
    rd(0, EL_ACCUMULATED, 32'h5);
    wr(0, EL_COUNT_ENABLE, 1);
    wr(3, EL_FUNCTION_ACTIVE, 1);
    wr(3, EL_COUNT_ENABLE, 1);
    src.pulse(2, 3);
    rd(3, EL_ACCUMULATED, 32'h3);
    rd(0, EL_ACCUMULATED, 32'h5);
    // High preset event drives outputs and a routine request
    wr(0, EL_UPPER_PATTERN, 32'h5a5a);
    wr(0, EL_UPPER_MASK, 1);
    wr(0, EL_ROUTINE_ENABLE, 1);
    wr(0, EL_UPPER_PRESET, 32'h7);
    rd(0, EL_UPPER_PRESET, 32'h7);
    src.pulse(0, 2);
    rd(0, EL_ACCUMULATED, 32'h0);
    rd(0, EL_MODE_DONE, 32'h1);
    rd(0, EL_UPPER_IRQ, 32'h1);
    chk("outputs", {16'h0, outs}, 32'h5a);
    chk("request", {26'h0, rreq}, 32'h1);
    @(negedge clk_i) rstart = 6'h01;
    @(negedge clk_i) rstart = 6'h00;
    chk("request", {26'h0, rreq}, 32'h0);
    rd(0, EL_EXECUTING, 32'h1);
    @(negedge clk_i) rdone = 6'h01;
    @(negedge clk_i) rdone = 6'h00;
    rd(0, EL_EXECUTING, 32'h0);
    // Auto start on entering run, then count down in mode 2
    wr(1, EL_UPPER_PRESET, 32'h64);
    cfg[1].start_on_run = 1'b1;
    load(1, 16'h3, 16'h2, 16'h0);
    rd(1, EL_START_ON_RUN, 32'h1);
    @(negedge clk_i) run_mode = 1'b1;
    rd(1, EL_FUNCTION_ACTIVE, 32'h1);
    wr(1, EL_COUNT_ENABLE, 1);
    src.level(5, 1'b1);
    src.pulse(4, 2);
    rd(1, EL_ACCUMULATED, 32'hfffffffe);
    rd(1, EL_DIRECTION, 32'h1);
    rd(1, EL_COUNTING_DOWN, 32'h1);
    end_sim();
  end
endmodule
